// file: fpec_defs.svh
// Constants for the flash program/erase control block.
// Assumes a single aclk domain; included by both design files.
`ifndef FPEC_DEFS_SVH
`define FPEC_DEFS_SVH

`define FPEC_ADDR_W 16
`define FPEC_PROTECT_ADDR 16'hFF8D
`define FPEC_CTRL_ADDR 16'hFF88
`define FPEC_OPADDR_ADDR 16'hFF90
`define FPEC_STATUS_ADDR 16'hFF94

`define FPEC_BIT_PGM 0
`define FPEC_BIT_ERASE 1
`define FPEC_BIT_MARGIN 2
`define FPEC_BIT_HIGH_VOLTAGE_ENABLE 3
`define FPEC_BIT_SIZE_LO 4
`define FPEC_BIT_SIZE_HI 5
`define FPEC_BIT_DIV_LO 6
`define FPEC_BIT_DIV_HI 7

`define FPEC_CTRL_RESET 8'h00
`define FPEC_PROTECT_RESET 8'h00
`define FPEC_ARRAY_LAST 16'h2FFF
`define FPEC_PROTECT_SHIFT 6

`define FPEC_RESP_OKAY 2'h0
`define FPEC_RESP_SLVERR 2'h2

`endif

// file: fpec_pkg.sv
// Types for the flash program/erase control block.
// Assumes fpec_defs.svh is compiled alongside.
package fpec_pkg;

  typedef enum logic [4:0] {
    fpec_idle_st = 5'h01,
    fpec_armed_st = 5'h02,
    fpec_checked_st = 5'h04,
    fpec_loaded_st = 5'h08,
    fpec_hv_st = 5'h10
  } fpec_seq_type;

  typedef enum logic [1:0] {
    fpec_div1_type = 2'h0,
    fpec_div2a_type = 2'h1,
    fpec_div2b_type = 2'h2,
    fpec_div4_type = 2'h3
  } fpec_div_type;

endpackage : fpec_pkg

// file: fpec_pump_div.sv
// Charge-pump clock enable divider.
// Assumes one aclk domain; pulse is a one-cycle enable.
`include "fpec_defs.svh"

module fpec_pump_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic pulse
);

  logic [1:0] count;
  logic [1:0] limit;

  always_comb begin
    case (sel)
      fpec_pkg::fpec_div1_type: limit = 2'h0;
      fpec_pkg::fpec_div2a_type: limit = 2'h1;
      fpec_pkg::fpec_div2b_type: limit = 2'h1;
      default: limit = 2'h3;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count <= 2'h0;
    end else if (count >= limit) begin
      count <= 2'h0;
    end else begin
      count <= count + 2'h1;
    end
  end

  // Pulse only while the pump runs, so an idle array sees no pump clock
  assign pulse = run && (count >= limit);

endmodule : fpec_pump_div

// file: fpec_flash_ctrl.sv
// Flash program/erase control: AXI4-Lite registers, interlocks, pump enable.
// Assumes aclk at 100 MHz, synchronous active-low reset, one AXI master.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "fpec_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - High voltage sets only after proper sequence
// - High voltage bit drives pump and array
// - Margin bit refused while high voltage on
// - Margin bit selects margin read mode
// - Erase and program never both set
// - Program bit selects program mode
// - Two divider bits choose pump clock divide
// - Two size bits choose erase region
// - Protected regions block program and erase at an address loaded inside them
// - Size encoding full, half, 256, 32 bytes
// - Divider encoding 1, 2, 2, 4
module fpec_flash_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pump_on,
  output logic pump_clk_en,
  output logic array_hv,
  output logic program_pulse,
  output logic erase_pulse,
  output logic margin_read,
  output logic [1:0] erase_size,
  output logic [15:0] erase_first,
  output logic [15:0] erase_last
);

  logic [7:0] flash_operation_control;
  logic [7:0] flash_block_protect;
  logic [15:0] op_addr;
  logic op_blocked;
  fpec_pkg::fpec_seq_type seq;

  logic aw_held;
  logic w_held;
  logic [15:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic rd_go;
  logic [7:0] wbyte;
  logic [15:0] wword;
  logic protect_hit;
  logic [15:0] span;

  logic program_select;
  logic erase_select;
  logic margin_select;
  logic high_voltage_enable;
  logic [1:0] next_size;
  logic next_pgm;
  logic next_erase;
  logic next_margin;
  logic next_hv;

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels; address and data taken in either order

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wbyte = w_strb[0] ? w_data[7:0] : 8'h00;
  assign wword = {w_strb[1] ? w_data[15:8] : 8'h00, wbyte};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 16'h0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPEC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        `FPEC_CTRL_ADDR, `FPEC_PROTECT_ADDR, `FPEC_OPADDR_ADDR,
        `FPEC_STATUS_ADDR: s_axi_bresp <= `FPEC_RESP_OKAY;
        default: s_axi_bresp <= `FPEC_RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register with interlocks

  assign program_select = flash_operation_control[`FPEC_BIT_PGM];
  assign erase_select = flash_operation_control[`FPEC_BIT_ERASE];
  assign margin_select = flash_operation_control[`FPEC_BIT_MARGIN];
  assign high_voltage_enable = flash_operation_control[`FPEC_BIT_HIGH_VOLTAGE_ENABLE];

  always_comb begin
    next_pgm = wbyte[`FPEC_BIT_PGM];
    next_erase = wbyte[`FPEC_BIT_ERASE];
    // Both asked at once: keep whichever was already held, else neither
    if (next_pgm && next_erase) begin
      next_pgm = program_select && !erase_select;
      next_erase = erase_select && !program_select;
    end
    next_hv = wbyte[`FPEC_BIT_HIGH_VOLTAGE_ENABLE];
    // Rising high voltage needs a selected operation and a loaded address
    if (next_hv && !high_voltage_enable) begin
      next_hv = (next_pgm || next_erase) && (seq == fpec_pkg::fpec_loaded_st)
        && !op_blocked;
    end
    if (!(next_pgm || next_erase)) begin
      next_hv = 1'b0;
    end
    next_margin = wbyte[`FPEC_BIT_MARGIN] && !next_hv && !high_voltage_enable;
    next_size = {wbyte[`FPEC_BIT_SIZE_HI], wbyte[`FPEC_BIT_SIZE_LO]};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_operation_control <= `FPEC_CTRL_RESET;
    end else if (wr_go && aw_addr == `FPEC_CTRL_ADDR && w_strb[0]) begin
      flash_operation_control <= {wbyte[`FPEC_BIT_DIV_HI], wbyte[`FPEC_BIT_DIV_LO],
        next_size, next_hv, next_margin, next_erase, next_pgm};
    end else if (high_voltage_enable && margin_select) begin
      flash_operation_control[`FPEC_BIT_MARGIN] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_block_protect <= `FPEC_PROTECT_RESET;
    end else if (wr_go && aw_addr == `FPEC_PROTECT_ADDR && w_strb[0]
        && !high_voltage_enable) begin
      flash_block_protect <= wbyte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operation sequence: select, protect read, address load, high voltage

  // Protect value N guards array offsets from N << 6 upward; zero guards none
  assign protect_hit = (flash_block_protect != 8'h00) && ({2'h0, wword} >=
    ({10'h000, flash_block_protect} << `FPEC_PROTECT_SHIFT));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_addr <= 16'h0000;
      op_blocked <= 1'b0;
    end else if (wr_go && aw_addr == `FPEC_OPADDR_ADDR && w_strb[1:0] == 2'h3
        && !high_voltage_enable) begin
      op_addr <= wword;
      op_blocked <= (wword > `FPEC_ARRAY_LAST) || protect_hit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq <= fpec_pkg::fpec_idle_st;
    end else if (!(program_select || erase_select)) begin
      seq <= fpec_pkg::fpec_idle_st;
    end else begin
      case (seq)
        fpec_pkg::fpec_idle_st: seq <= fpec_pkg::fpec_armed_st;
        fpec_pkg::fpec_armed_st:
          if (rd_go && s_axi_araddr == `FPEC_PROTECT_ADDR) begin
            seq <= fpec_pkg::fpec_checked_st;
          end
        fpec_pkg::fpec_checked_st:
          if (wr_go && aw_addr == `FPEC_OPADDR_ADDR && w_strb[1:0] == 2'h3) begin
            seq <= fpec_pkg::fpec_loaded_st;
          end
        fpec_pkg::fpec_loaded_st:
          if (high_voltage_enable) begin
            seq <= fpec_pkg::fpec_hv_st;
          end
        fpec_pkg::fpec_hv_st:
          // Back to loaded after high voltage drops so program can repeat pulses
          if (!high_voltage_enable) begin
            seq <= fpec_pkg::fpec_loaded_st;
          end
        default: seq <= fpec_pkg::fpec_idle_st;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, single cycle answer

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FPEC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FPEC_RESP_OKAY;
      case (s_axi_araddr)
        `FPEC_CTRL_ADDR: s_axi_rdata <= {24'h000000, flash_operation_control};
        `FPEC_PROTECT_ADDR: s_axi_rdata <= {24'h000000, flash_block_protect};
        `FPEC_OPADDR_ADDR: s_axi_rdata <= {16'h0000, op_addr};
        `FPEC_STATUS_ADDR: s_axi_rdata <= {26'h0000000, op_blocked, seq};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `FPEC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Array and pump outputs

  fpec_pump_div u_pump_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(high_voltage_enable),
    .sel(flash_operation_control[`FPEC_BIT_DIV_HI:`FPEC_BIT_DIV_LO]),
    .pulse(pump_clk_en)
  );

  // Size decode gives the erased span; 12K array has no power-of-two half mask
  always_comb begin
    case (erase_size)
      2'h0: span = 16'h2FFF;
      2'h1: span = 16'h17FF;
      2'h2: span = 16'h00FF;
      default: span = 16'h001F;
    endcase
  end

  always_comb begin
    case (erase_size)
      2'h0: erase_first = 16'h0000;
      2'h1: erase_first = (op_addr >= 16'h1800) ? 16'h1800 : 16'h0000;
      2'h2: erase_first = {op_addr[15:8], 8'h00};
      default: erase_first = {op_addr[15:5], 5'h00};
    endcase
  end

  assign erase_last = erase_first + span;
  assign erase_size = flash_operation_control[`FPEC_BIT_SIZE_HI:`FPEC_BIT_SIZE_LO];
  assign pump_on = high_voltage_enable;
  assign array_hv = high_voltage_enable;
  assign program_pulse = high_voltage_enable && program_select;
  assign erase_pulse = high_voltage_enable && erase_select;
  assign margin_read = margin_select;

  // program mode follows program_select through program_pulse

endmodule : fpec_flash_ctrl

// file: fpec_flash_ctrl_asserts.sv
// Output checks for the flash program/erase control block.
// Assumes binding to fpec_flash_ctrl; one aclk domain, sync reset.
module fpec_flash_ctrl_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pump_on,
  input wire logic pump_clk_en,
  input wire logic array_hv,
  input wire logic program_pulse,
  input wire logic erase_pulse,
  input wire logic margin_read,
  input wire logic [1:0] erase_size,
  input wire logic [15:0] erase_first,
  input wire logic [15:0] erase_last
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Span is last minus first, so a region that is off by one byte shows up
  function automatic logic [15:0] span(input logic [1:0] s);
    case (s)
      2'h0: span = 16'h2FFF;
      2'h1: span = 16'h17FF;
      2'h2: span = 16'h00FF;
      default: span = 16'h001F;
    endcase
  endfunction : span
  ////////////////////////////////////////
  property p_pump; pump_on == array_hv; endproperty
  a_pump: assert property (p_pump) else $error("pump differs from hv");
  property p_prog; program_pulse |-> array_hv && !erase_pulse; endproperty
  a_prog: assert property (p_prog) else $error("bad program pulse");
  property p_erase; erase_pulse |-> array_hv; endproperty
  a_erase: assert property (p_erase) else $error("erase pulse without hv");
  property p_hv_op; array_hv |-> program_pulse || erase_pulse; endproperty
  a_hv_op: assert property (p_hv_op) else $error("hv without operation");
  property p_mrg_rise; $rose(margin_read) |-> !array_hv; endproperty
  a_mrg_rise: assert property (p_mrg_rise) else $error("margin set under hv");
  property p_mrg_clr; array_hv [*2] |-> !margin_read; endproperty
  a_mrg_clr: assert property (p_mrg_clr) else $error("margin kept under hv");
  property p_clk_en; pump_clk_en |-> array_hv; endproperty
  a_clk_en: assert property (p_clk_en) else $error("pump clock while hv off");
  property p_span; erase_last - erase_first == span(erase_size); endproperty
  a_span: assert property (p_span) else $error("erase span wrong");
  property p_rst;
    disable iff (1'b0) !aresetn |=> !array_hv && !margin_read && erase_size == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset");
  c_hv: cover property ($rose(array_hv));
  c_mrg: cover property ($rose(margin_read));
  c_prog: cover property (program_pulse);
endmodule : fpec_flash_ctrl_asserts

bind fpec_flash_ctrl fpec_flash_ctrl_asserts u_chk (.aclk, .aresetn, .pump_on, .pump_clk_en,
  .array_hv, .program_pulse, .erase_pulse, .margin_read, .erase_size, .erase_first, .erase_last);

// file: tb_top.sv
// Self-checking bench for the flash program/erase control block.
// Assumes fpec_flash_ctrl with its bound checker; bready and rready held high.
`include "fpec_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [15:0] awaddr, araddr, erase_first, erase_last;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, rsp, erase_size;
  logic pump_on, pump_clk_en, array_hv, program_pulse, erase_pulse, margin_read;
  int fail_count = 0;
  int n_checks = 0;
  int dv[4] = '{1, 2, 2, 4};
  int ef[4] = '{0, 0, 0, 32};
  int el[4] = '{32'h2FFF, 32'h17FF, 32'hFF, 32'h3F};
  fpec_flash_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .pump_on, .pump_clk_en,
    .array_hv, .program_pulse, .erase_pulse, .margin_read, .erase_size, .erase_first,
    .erase_last);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////
  task automatic wrap_up();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Both channels offered together; each dropped at the edge that takes it
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 40) chk("write answer", 1'b0, 1'b1);
    if (k == 40) wrap_up();
    rsp = bresp;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 40) chk("read answer", 1'b0, 1'b1);
    if (k == 40) wrap_up();
    v = rdata;
    rsp = rresp;
  endtask : rd
  task automatic wc(input logic [7:0] c);
    wr(`FPEC_CTRL_ADDR, {24'h0, c});
  endtask : wc
  task automatic erase_on(input logic [1:0] d, input logic [1:0] s, input logic [15:0] a);
    wc({d, s, 4'b0010});
    rd(`FPEC_PROTECT_ADDR);
    wr(`FPEC_OPADDR_ADDR, {16'h0, a});
    wc({d, s, 4'b1010});
  endtask : erase_on
  ////////////////////////////////////////
  task automatic t_basic();
    rd(`FPEC_CTRL_ADDR);
    chk("ctrl reset", v, `FPEC_CTRL_RESET);
    chk("read resp", rsp, `FPEC_RESP_OKAY);
    rd(`FPEC_PROTECT_ADDR);
    chk("protect reset", v, `FPEC_PROTECT_RESET);
    wc(8'h03);
    chk("write resp", rsp, `FPEC_RESP_OKAY);
    rd(`FPEC_CTRL_ADDR);
    chk("both ops", v[1:0], 2'h0);
    wc(8'h01);
    wc(8'h03);
    rd(`FPEC_CTRL_ADDR);
    chk("program kept", v[1:0], 2'h1);
    chk("no pulse", program_pulse, 1'b0);
    wc(8'h09);
    chk("early hv", array_hv, 1'b0);
    wc(8'h04);
    chk("margin on", margin_read, 1'b1);
    wc(8'h00);
    chk("margin off", margin_read, 1'b0);
    rd(16'hFF00);
    chk("unmapped data", v, 32'h0);
    chk("unmapped resp", rsp, `FPEC_RESP_SLVERR);
  endtask : t_basic
  task automatic t_erase();
    int n;
    for (int i = 0; i < 4; i++) begin
      erase_on(i[1:0], i[1:0], 16'h0020);
      chk("hv", {array_hv, pump_on, erase_pulse}, 3'h7);
      chk("size", erase_size, i[1:0]);
      chk("erase first", erase_first, ef[i]);
      chk("erase last", erase_last, el[i]);
      n = 0;
      repeat (8) begin
        @(posedge aclk);
        n += pump_clk_en;
      end
      chk("pump ticks", n, 8 / dv[i]);
      wc({i[1:0], i[1:0], 4'b1110});
      chk("margin under hv", margin_read, 1'b0);
      wc({i[1:0], i[1:0], 4'b0010});
      chk("hv off", {array_hv, pump_on}, 2'h0);
      wc(8'h00);
    end
  endtask : t_erase
  // Protect value 1 guards everything from byte 64 upward
  task automatic t_protect();
    wr(`FPEC_PROTECT_ADDR, 32'h1);
    erase_on(2'h0, 2'h3, 16'h0100);
    chk("guarded", array_hv, 1'b0);
    wc(8'h00);
    erase_on(2'h0, 2'h3, 16'h0010);
    chk("open", array_hv, 1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset hv", {array_hv, margin_read}, 2'h0);
    rd(`FPEC_CTRL_ADDR);
    chk("reset ctrl", v, `FPEC_CTRL_RESET);
  endtask : t_protect
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {awaddr, araddr, wdata} = 64'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_basic();
    t_erase();
    t_protect();
    wrap_up();
  end
endmodule : tb_top
